// >>> pkg/vepd_pkg.sv
// Package for the execute packet dispatch front end
package vepd_pkg;
    localparam int FETCH_W      = 256;
    localparam int SLOTS        = 8;
    localparam int INSN_W       = 32;
    localparam int UNITS        = 8;
    localparam int REGS         = 16;
    localparam int RIDX_W       = 4;
    // Instruction field positions
    localparam int CHAIN_BIT    = 0;
    localparam int UNIT_LSB     = 1;
    localparam int UNIT_MSB     = 3;
    localparam int XPATH_BIT    = 4;
    localparam int MEMSZ_LSB    = 5;
    localparam int MEMSZ_MSB    = 6;
    localparam int CIRC_BIT     = 7;
    localparam int LONGOFS_BIT  = 8;
    localparam int DST_LSB      = 9;
    localparam int DST_MSB      = 12;
    localparam int SRC_LSB      = 13;
    localparam int SRC_MSB      = 16;
    localparam int SRC2_LSB     = 17;
    localparam int SRC2_MSB     = 20;
    localparam int OFS_LSB      = 21;
    localparam int OFS5_MSB     = 25;
    // Long offset form reuses the register index bits, so it fits inside one word
    localparam int OFS15_LSB    = 14;
    localparam int OFS15_MSB    = 28;
    localparam int COND_LSB     = 29;
    localparam int COND_MSB     = 31;
    localparam logic [2:0] COND_ALWAYS = 3'h0;
    // Unit encodings, side a then side b
    localparam logic [2:0] U_LOGIC_A = 3'h0;
    localparam logic [2:0] U_SHIFT_A = 3'h1;
    localparam logic [2:0] U_MULT_A  = 3'h2;
    localparam logic [2:0] U_DATA_A  = 3'h3;
    localparam logic [2:0] U_LOGIC_B = 3'h4;
    localparam logic [2:0] U_SHIFT_B = 3'h5;
    localparam logic [2:0] U_MULT_B  = 3'h6;
    localparam logic [2:0] U_DATA_B  = 3'h7;
    localparam logic [1:0] SZ_BYTE   = 2'h0;
    localparam logic [1:0] SZ_HALF   = 2'h1;
    localparam logic [1:0] SZ_WORD   = 2'h2;

    typedef struct packed {
        logic [SLOTS-1:0]              valid;
        logic [SLOTS-1:0][INSN_W-1:0]  insn;
    } vepd_group_t;

    typedef struct packed {
        logic [UNITS-1:0]              active;
        logic [UNITS-1:0][INSN_W-1:0]  insn;
        logic [UNITS-1:0]              cond_always;
    } vepd_issue_t;

    typedef struct packed {
        logic              valid;
        logic              circular;
        logic [14:0]       offset;
        logic [1:0]        size;
        logic              store;
        logic              data_side_b;
        logic [RIDX_W-1:0] data_reg;
        logic [RIDX_W-1:0] base_reg;
    } vepd_mem_t;
endpackage

// >>> core/vepd_regfile.sv
// One side's 16 by 32 register file with local and cross ports
`timescale 1ns/1ps
module vepd_regfile
    import vepd_pkg::*;
(
    input  wire logic                        ref_clk_in,
    input  wire logic                        sys_rst_in,
    input  wire logic                        clk_en_in,
    input  wire logic [3:0][RIDX_W-1:0]      rd_idx_in,
    output logic      [3:0][INSN_W-1:0]      rd_data_out,
    input  wire logic [3:0]                  wr_en_in,
    input  wire logic [3:0][RIDX_W-1:0]      wr_idx_in,
    input  wire logic [3:0][INSN_W-1:0]      wr_data_in,
    input  wire logic [RIDX_W-1:0]           x_rd_idx_in,
    output logic      [INSN_W-1:0]           x_rd_data_out,
    input  wire logic                        x_wr_en_in,
    input  wire logic [RIDX_W-1:0]           x_wr_idx_in,
    input  wire logic [INSN_W-1:0]           x_wr_data_in
);
    import vepd_pkg::*;
    logic [REGS-1:0][INSN_W-1:0] regs_q;

    // Four local read ports serve all units of the side in one cycle
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_data_out   <= '0;
            x_rd_data_out <= '0;
        end else if (clk_en_in) begin
            for (int i = 0; i < 4; i++) begin
                rd_data_out[i] <= regs_q[rd_idx_in[i]];
            end
            x_rd_data_out <= regs_q[x_rd_idx_in];
        end
    end

    // Single cross write port, lowest priority against local writes
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            regs_q <= '0;
        end else if (clk_en_in) begin
            if (x_wr_en_in) begin
                regs_q[x_wr_idx_in] <= x_wr_data_in;
            end
            for (int i = 0; i < 4; i++) begin
                if (wr_en_in[i]) begin
                    regs_q[wr_idx_in[i]] <= wr_data_in[i];
                end
            end
        end
    end
endmodule

// >>> core/vepd_dispatch.sv
// Fetch, execute packet split and unit dispatch front end
//
// Operation
// - Each fetch reads one 256-bit packet of eight 32-bit slots.
// - A set low bit chains the next slot into the same execute packet.
// - A clear low bit ends the packet, and the next slot issues on a later cycle.
// - A fetch packet may split into one to eight packets of any length.
// - At most one execute packet is sent per cycle to its target units.
// - The next fetch waits until every packet of the current one is dispatched.
// - Units with no instruction in a packet stay idle that cycle.
// - The core has two sides of four units, each with its own register file.
// - Each side has 16 registers of 32 bits reachable by its four units each cycle.
// - Opposite side access uses one cross path with one read and one write per cycle.
// - Only the data-address units move data to memory, possibly to the other side's file.
// - Indirect addressing has linear and circular modes with 5 or 15 bit offsets.
// - Every instruction is conditional, and only the always case is unconditional.
// - Multiply units take multiplies; logic and shift units take the rest each cycle.
// - Loads and stores carry byte, half-word or word size.
`timescale 1ns/1ps
module vepd_dispatch
    import vepd_pkg::*;
(
    input  wire logic                        ref_clk_in,
    input  wire logic                        sys_rst_in,
    input  wire logic                        clk_en_in,
    output logic                             fetch_req_out,
    input  wire logic                        fetch_valid_in,
    input  wire logic [FETCH_W-1:0]          fetch_data_in,
    output vepd_pkg::vepd_issue_t            issue_out,
    output logic                             issue_valid_out,
    output logic                             xpath_conflict_out,
    output vepd_pkg::vepd_mem_t              mem_a_out,
    output vepd_pkg::vepd_mem_t              mem_b_out,
    input  wire logic [UNITS-1:0]            wb_en_in,
    input  wire logic [UNITS-1:0][INSN_W-1:0] wb_data_in,
    output logic      [UNITS-1:0][INSN_W-1:0] operand_out,
    output logic      [1:0][INSN_W-1:0]      xpath_data_out
);
    import vepd_pkg::*;

    typedef enum logic [1:0] {ST_FETCH, ST_WAIT, ST_ISSUE} vepd_state_t;

    vepd_state_t                  state_q;
    logic [SLOTS-1:0][INSN_W-1:0] pkt_q;
    logic [SLOTS-1:0]             pend_q;
    logic [SLOTS-1:0]             grp_mask;
    logic                         last_grp;
    vepd_issue_t                  issue_d;
    logic [1:0]                   x_rd_cnt;
    logic [1:0]                   x_wr_cnt;
    logic [1:0]                   x_multi;
    vepd_issue_t                  held_q;

    function automatic logic [2:0] unit_of(input logic [INSN_W-1:0] w);
        return w[UNIT_MSB:UNIT_LSB];
    endfunction

    function automatic logic side_b(input logic [2:0] u);
        return u[2];
    endfunction

    function automatic vepd_mem_t mem_of(input logic [INSN_W-1:0] w, input logic act, input logic own_b);
        vepd_mem_t m;
        m = '0;
        m.valid       = act;
        m.circular    = w[CIRC_BIT];
        m.offset      = w[LONGOFS_BIT] ? w[OFS15_MSB:OFS15_LSB]
                                       : {10'h000, w[OFS5_MSB:OFS_LSB]};
        m.size        = (w[MEMSZ_MSB:MEMSZ_LSB] == 2'h3) ? SZ_WORD : w[MEMSZ_MSB:MEMSZ_LSB];
        m.store       = w[CHAIN_BIT+27];
        m.data_side_b = own_b ^ w[XPATH_BIT];
        m.data_reg    = w[DST_MSB:DST_LSB];
        m.base_reg    = w[SRC_MSB:SRC_LSB];
        return m;
    endfunction

    // Chain walk from the lowest pending slot until a clear chain bit
    always_comb begin
        logic started;
        logic open;
        started  = 1'b0;
        open     = 1'b1;
        grp_mask = '0;
        for (int i = 0; i < SLOTS; i++) begin
            if (pend_q[i] && open) begin
                grp_mask[i] = 1'b1;
                started     = 1'b1;
                if (!pkt_q[i][CHAIN_BIT]) begin
                    open = 1'b0;
                end
            end else if (started) begin
                open = 1'b0;
            end
        end
        last_grp = ((pend_q & ~grp_mask) == '0);
    end

    // Route each slot of the packet to its unit; no slot means idle
    always_comb begin
        issue_d  = '0;
        x_rd_cnt = '0;
        x_wr_cnt = '0;
        x_multi  = '0;
        for (int i = 0; i < SLOTS; i++) begin
            if (grp_mask[i]) begin
                issue_d.active[unit_of(pkt_q[i])]      = 1'b1;
                issue_d.insn[unit_of(pkt_q[i])]        = pkt_q[i];
                issue_d.cond_always[unit_of(pkt_q[i])] =
                    (pkt_q[i][COND_MSB:COND_LSB] == COND_ALWAYS);
            end
        end
        for (int u = 0; u < 4; u++) begin
            if (issue_d.active[u] && issue_d.insn[u][XPATH_BIT]) begin
                x_multi[0]  = x_multi[0] | x_rd_cnt[0];
                x_rd_cnt[0] = 1'b1;
            end
        end
        for (int u = 4; u < UNITS; u++) begin
            if (issue_d.active[u] && issue_d.insn[u][XPATH_BIT]) begin
                x_multi[1]  = x_multi[1] | x_rd_cnt[1];
                x_rd_cnt[1] = 1'b1;
            end
        end
        x_wr_cnt = x_rd_cnt;
    end

    // Fetch sequencing: one packet held until drained
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= ST_FETCH;
            pend_q  <= '0;
            pkt_q   <= '0;
        end else if (clk_en_in) begin
            case (state_q)
                ST_FETCH: begin
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (fetch_valid_in) begin
                        pkt_q   <= fetch_data_in;
                        pend_q  <= '1;
                        state_q <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    pend_q <= pend_q & ~grp_mask;
                    if (last_grp) begin
                        state_q <= ST_FETCH;
                    end
                end
                default: begin
                    state_q <= ST_FETCH;
                end
            endcase
        end
    end

    assign fetch_req_out = (state_q == ST_FETCH);

    // Issue register; idle units see zero
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            issue_out          <= '0;
            issue_valid_out    <= 1'b0;
            xpath_conflict_out <= 1'b0;
            mem_a_out          <= '0;
            mem_b_out          <= '0;
            held_q             <= '0;
        end else if (clk_en_in) begin
            issue_valid_out <= (state_q == ST_ISSUE);
            issue_out       <= (state_q == ST_ISSUE) ? issue_d : '0;
            held_q          <= (state_q == ST_ISSUE) ? issue_d : '0;
            // Several units on one side asking the cross path is a code fault, flagged not stalled
            xpath_conflict_out <= (state_q == ST_ISSUE) && (x_multi != 2'h0) && (x_wr_cnt != 2'h0);
            mem_a_out <= mem_of(issue_d.insn[U_DATA_A], (state_q == ST_ISSUE) && issue_d.active[U_DATA_A], 1'b0);
            mem_b_out <= mem_of(issue_d.insn[U_DATA_B], (state_q == ST_ISSUE) && issue_d.active[U_DATA_B], 1'b1);
        end
    end

    // Register files, two sides of four units
    logic [1:0][3:0][INSN_W-1:0] rd_data;
    logic [1:0][INSN_W-1:0]      x_rd;
    logic [1:0][3:0][RIDX_W-1:0] rd_idx;
    logic [1:0][3:0]             wr_en;
    logic [1:0][3:0][RIDX_W-1:0] wr_idx;
    logic [1:0][3:0][INSN_W-1:0] wr_dat;
    logic [1:0][RIDX_W-1:0]      x_rd_idx;
    logic [1:0]                  x_wr_en;
    logic [1:0][RIDX_W-1:0]      x_wr_idx;
    logic [1:0][INSN_W-1:0]      x_wr_dat;

    always_comb begin
        rd_idx   = '0;
        wr_en    = '0;
        wr_idx   = '0;
        wr_dat   = '0;
        x_rd_idx = '0;
        x_wr_en  = '0;
        x_wr_idx = '0;
        x_wr_dat = '0;
        for (int s = 0; s < 2; s++) begin
            for (int u = 0; u < 4; u++) begin
                rd_idx[s][u] = issue_d.insn[s*4+u][SRC_MSB:SRC_LSB];
                wr_idx[s][u] = held_q.insn[s*4+u][DST_MSB:DST_LSB];
                wr_dat[s][u] = wb_data_in[s*4+u];
                wr_en[s][u]  = wb_en_in[s*4+u] && !held_q.insn[s*4+u][XPATH_BIT];
            end
            // One read and one write cross the sides: lowest-numbered requesting unit wins
            for (int u = 3; u >= 0; u--) begin
                if (held_q.active[(1-s)*4+u] && held_q.insn[(1-s)*4+u][XPATH_BIT]) begin
                    x_rd_idx[s] = held_q.insn[(1-s)*4+u][SRC2_MSB:SRC2_LSB];
                    x_wr_en[s]  = wb_en_in[(1-s)*4+u];
                    x_wr_idx[s] = held_q.insn[(1-s)*4+u][DST_MSB:DST_LSB];
                    x_wr_dat[s] = wb_data_in[(1-s)*4+u];
                end
            end
        end
    end

    for (genvar s = 0; s < 2; s++) begin : g_side
        vepd_regfile u_rf (
            .ref_clk_in    (ref_clk_in),
            .sys_rst_in    (sys_rst_in),
            .clk_en_in     (clk_en_in),
            .rd_idx_in     (rd_idx[s]),
            .rd_data_out   (rd_data[s]),
            .wr_en_in      (wr_en[s]),
            .wr_idx_in     (wr_idx[s]),
            .wr_data_in    (wr_dat[s]),
            .x_rd_idx_in   (x_rd_idx[s]),
            .x_rd_data_out (x_rd[s]),
            .x_wr_en_in    (x_wr_en[s]),
            .x_wr_idx_in   (x_wr_idx[s]),
            .x_wr_data_in  (x_wr_dat[s])
        );
    end

    assign operand_out    = {rd_data[1], rd_data[0]};
    assign xpath_data_out = {x_rd[0], x_rd[1]};

    // Assertions
    a_one_fetch_drain: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && state_q == ST_ISSUE && !last_grp) |=> !fetch_req_out)
        else $error("fetch requested while packet pending");
    a_issue_after_fetch: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && state_q == ST_WAIT && fetch_valid_in) |=> (state_q == ST_ISSUE && pend_q == 8'hff))
        else $error("fetched packet not loaded");
    a_group_nonempty: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (state_q == ST_ISSUE) |-> (grp_mask != '0))
        else $error("empty execute packet");
    a_chain_stop: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (state_q == ST_ISSUE && grp_mask[0] && !pkt_q[0][CHAIN_BIT]) |-> (grp_mask[7:1] == '0))
        else $error("packet continued past clear chain bit");
    a_chain_join: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (state_q == ST_ISSUE && grp_mask[0] && pkt_q[0][CHAIN_BIT]) |-> grp_mask[1])
        else $error("chained slot not joined");
    a_drain_bound: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && state_q == ST_ISSUE && last_grp) |=> fetch_req_out)
        else $error("no refetch after last packet");
    a_idle_units: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && state_q != ST_ISSUE) |=> (issue_out.active == '0 && !issue_valid_out))
        else $error("unit active with no packet");
    a_reset_fetch: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        $fell(sys_rst_in) |-> (fetch_req_out && !issue_valid_out))
        else $error("issue before first fetch");
endmodule

// >>> verif/vepd_prog_mem.sv
// Behavioural program memory that answers fetch requests from a queue of packets
`timescale 1ns/1ps
module vepd_prog_mem
    import vepd_pkg::*;
(
    input  wire logic                ref_clk_in,
    input  wire logic                sys_rst_in,
    input  wire logic                clk_en_in,
    input  wire logic                fetch_req_in,
    output logic                     fetch_valid_out,
    output logic [FETCH_W-1:0]       fetch_data_out
);
    logic [FETCH_W-1:0] pkt_q[$];
    int                 dly_q[$];
    int                 wait_cnt;
    logic               pend;
    logic [FETCH_W-1:0] pkt;

    task automatic push(input logic [FETCH_W-1:0] p, input int d);
        pkt_q.push_back(p);
        dly_q.push_back(d);
    endtask

    initial begin
        fetch_valid_out = 1'b0;
        fetch_data_out  = '0;
        pend            = 1'b0;
        wait_cnt        = 0;
    end

    // A slow answer is just a longer wait; data is never offered before a request
    always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            fetch_valid_out <= 1'b0;
            pend            <= 1'b0;
            wait_cnt        <= 0;
        end else if (clk_en_in) begin
            if (!fetch_valid_out && (pend || fetch_req_in) && pkt_q.size() != 0 && wait_cnt >= dly_q[0]) begin
                pkt      = pkt_q.pop_front();
                void'(dly_q.pop_front());
                pkt[224] = 1'b0;
                fetch_data_out  <= pkt;
                fetch_valid_out <= 1'b1;
                pend            <= 1'b0;
                wait_cnt        <= 0;
            end else begin
                // Bus not carrying a packet inverts every bit each cycle, so the last packet reappears every other cycle
                fetch_data_out  <= ~fetch_data_out;
                fetch_valid_out <= 1'b0;
                if (pend || fetch_req_in) begin
                    pend     <= 1'b1;
                    wait_cnt <= wait_cnt + 1;
                end
            end
        end
    end
endmodule

// >>> verif/vliw_execute_packet_dispatch_tb_top.sv
// Testbench for the execute packet dispatch front end
`timescale 1ns/1ps
module vliw_execute_packet_dispatch_tb_top;
    import vepd_pkg::*;
    typedef struct packed {
        logic [7:0]  chain;
        logic [23:0] units;
        logic [27:0] fill;
        logic [3:0]  dly;
        logic [3:0]  ngrp;
    } vepd_row_t;
    // Chain mask, slot units, field pattern, memory wait, expected packet count
    localparam vepd_row_t ROWS [5] = '{
        '{8'h7f, 24'hfac688, 28'h1a2b3c4, 4'h0, 4'h1},
        '{8'h00, 24'hfac688, 28'h5e6f701, 4'h2, 4'h8},
        '{8'h35, 24'h053977, 28'h0f0e0d0, 4'h1, 4'h4},
        '{8'h03, 24'hfac7db, 28'h7654321, 4'h0, 4'h6},
        '{8'h55, 24'hfac688, 28'h2468ace, 4'h5, 4'h4}};
    logic                          ref_clk_in;
    logic                          sys_rst_in;
    logic                          clk_en_in;
    logic                          fetch_req_out;
    logic                          fetch_valid_in;
    logic [FETCH_W-1:0]            fetch_data_in;
    vepd_issue_t                   issue_out;
    logic                          issue_valid_out;
    logic                          xpath_conflict_out;
    vepd_mem_t                     mem_a_out;
    vepd_mem_t                     mem_b_out;
    logic [UNITS-1:0]              wb_en_in;
    logic [UNITS-1:0][INSN_W-1:0]  wb_data_in;
    logic [UNITS-1:0][INSN_W-1:0]  operand_out;
    logic [1:0][INSN_W-1:0]        xpath_data_out;
    vepd_issue_t                   exp_q[$];
    int                            grp_q[$];
    int                            error_cnt = 0;
    int                            checked = 0;
    int                            issued = 0;
    int                            fetched = 0;
    int                            cyc = 0;
    int                            mark = 0;
    int                            first_cyc = 0;
    int                            last_cyc = 0;

    vepd_dispatch vepd_dispatch_i (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
        .fetch_req_out(fetch_req_out), .fetch_valid_in(fetch_valid_in), .fetch_data_in(fetch_data_in),
        .issue_out(issue_out), .issue_valid_out(issue_valid_out), .xpath_conflict_out(xpath_conflict_out),
        .mem_a_out(mem_a_out), .mem_b_out(mem_b_out), .wb_en_in(wb_en_in), .wb_data_in(wb_data_in),
        .operand_out(operand_out), .xpath_data_out(xpath_data_out));
    vepd_prog_mem vepd_prog_mem_i (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
        .fetch_req_in(fetch_req_out), .fetch_valid_out(fetch_valid_in), .fetch_data_out(fetch_data_in));

    initial begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end

    task automatic conclude();
        if (error_cnt == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [INSN_W-1:0] mk(input vepd_row_t r, input int i);
        logic [INSN_W-1:0] w;
        w = {r.fill + 28'(i) * 28'h4c2d1e3, r.units[3*i+:3], r.chain[i] & (i != 7)};
        w[4] = 1'b0;
        if (w[6:5] == 2'h3) w[6] = 1'b0;
        if (i % 3 == 0) w[31:29] = COND_ALWAYS;
        return w;
    endfunction

    // Later slot on the same unit replaces the earlier one in the expectation
    task automatic push_pkt(input vepd_row_t r);
        logic [FETCH_W-1:0] pkt;
        vepd_issue_t        e;
        logic [INSN_W-1:0]  w;
        int                 g;
        e = '0;
        g = 0;
        for (int i = 0; i < SLOTS; i++) begin
            w = mk(r, i);
            pkt[32*i+:32] = w;
            e.active[w[3:1]] = 1'b1;
            e.insn[w[3:1]] = w;
            e.cond_always[w[3:1]] = (w[31:29] == COND_ALWAYS);
            if (!w[0]) begin
                exp_q.push_back(e);
                e = '0;
                g++;
            end
        end
        grp_q.push_back(g);
        mark = issued;
        vepd_prog_mem_i.push(pkt, int'(r.dly));
    endtask

    task automatic chk_mem(input vepd_mem_t m, input logic [INSN_W-1:0] w);
        chk(32'(m.size), 32'(w[6:5]));
        chk(32'(m.circular), 32'(w[7]));
        chk(32'(m.store), 32'(w[27]));
    endtask

    task automatic cmp_issue(input vepd_issue_t e);
        chk(32'(issue_out.active), 32'(e.active));
        chk(32'(xpath_conflict_out), 32'h0);
        for (int u = 0; u < UNITS; u++) begin
            if (e.active[u]) begin
                chk(issue_out.insn[u], e.insn[u]);
                chk(32'(issue_out.cond_always[u]), 32'(e.cond_always[u]));
            end
        end
        chk(32'(mem_a_out.valid), 32'(e.active[3]));
        chk(32'(mem_b_out.valid), 32'(e.active[7]));
        if (e.active[3]) chk_mem(mem_a_out, e.insn[3]);
        if (e.active[7]) chk_mem(mem_b_out, e.insn[7]);
    endtask

    // Only enabled edges consume an output, so a frozen cycle is never counted twice
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc > 5000) begin
            error_cnt++;
            conclude();
        end
        if (sys_rst_in) begin
            issued = 0;
            fetched = 0;
        end else if (clk_en_in) begin
            if (issue_valid_out) begin
                chk(32'(issued < fetched && exp_q.size() != 0), 32'h1);
                if (exp_q.size() != 0) cmp_issue(exp_q.pop_front());
                if (issued == mark) first_cyc = cyc;
                last_cyc = cyc;
                issued++;
            end
            if (fetch_req_out) chk(32'(issued), 32'(fetched));
            if (fetch_valid_in && grp_q.size() != 0) fetched += grp_q.pop_front();
        end
    end

    task automatic wait_done();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 300) begin
            @(posedge ref_clk_in);
            n++;
        end
        chk(32'(exp_q.size()), 32'h0);
        repeat (4) @(posedge ref_clk_in);
    endtask

    initial begin
        sys_rst_in = 1'b1;
        clk_en_in  = 1'b1;
        wb_en_in   = '0;
        wb_data_in = '0;
        repeat (3) @(posedge ref_clk_in);
        chk(32'(fetch_req_out), 32'h1);
        chk(32'(issue_valid_out), 32'h0);
        sys_rst_in <= 1'b0;
        for (int r = 0; r < 5; r++) begin
            push_pkt(ROWS[r]);
            wait_done();
            chk(32'(issued - mark), 32'(ROWS[r].ngrp));
            chk(32'(last_cyc - first_cyc), 32'(ROWS[r].ngrp - 1));
        end
        // Freeze mid packet: nothing may be lost or repeated
        push_pkt(ROWS[1]);
        repeat (5) @(posedge ref_clk_in);
        clk_en_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        clk_en_in <= 1'b1;
        wait_done();
        chk(32'(issued - mark), 32'h8);
        // Reset once two packets of a fetch packet are dispatched, then a fresh one
        push_pkt(ROWS[1]);
        while (issued < mark + 2 && cyc < 4000) @(posedge ref_clk_in);
        sys_rst_in <= 1'b1;
        @(posedge ref_clk_in);
        exp_q.delete();
        grp_q.delete();
        @(posedge ref_clk_in);
        chk(32'(issue_valid_out), 32'h0);
        chk(32'(fetch_req_out), 32'h1);
        sys_rst_in <= 1'b0;
        push_pkt(ROWS[0]);
        wait_done();
        chk(32'(issued), 32'h1);
        conclude();
    end
endmodule
